/* File: aligned_clock_pkg.sv */
// Constants, register map and field layout of the aligned clock PLL divider.
// Assumes a single 50 MHz bus clock that also stands in for the PLL output clock.
package aligned_clock_pkg;

	localparam logic [7:0] CFG_OFFSET = 8'h00;
	localparam logic [7:0] LOCK_CFG_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;

	// Divider configuration register fields
	localparam int STAGE_A_POS = 0;
	localparam int CORE_TAP_POS = 2;
	localparam int APB0_TAP_POS = 5;
	localparam int APB1_TAP_POS = 8;
	localparam int FIC_A_TAP_POS = 11;
	localparam int FIC_B_TAP_POS = 14;
	localparam int MEM_FIC_TAP_POS = 17;
	localparam int SMC_MODE_POS = 20;
	localparam int CORE_GATE_POS = 21;
	localparam int STANDBY_POS = 22;
	localparam int USB_EN_POS = 23;
	localparam int CAN_EN_POS = 24;
	localparam int CFG_WIDTH = 25;
	// Stage A by 1, all taps by 1, standby bit set: the 1:1 power-on arrangement
	localparam logic [24:0] CFG_RESET = 25'h0400000;

	// Lock configuration register fields
	localparam int WINDOW_POS = 0;
	localparam int DELAY_POS = 4;
	localparam int MULT_POS = 8;
	localparam int LOCK_CFG_WIDTH = 13;
	localparam logic [12:0] LOCK_CFG_RESET = 13'h0100;

	// Status register bits
	localparam int ST_LOCK_POS = 0;
	localparam int ST_RAW_LOCK_POS = 1;
	localparam int ST_CFG_ERR_POS = 2;
	localparam int ST_STANDBY_POS = 3;

	localparam int TAP_COUNT = 8;
	localparam int CHAIN_BITS = 7;
	localparam int CFG_IF_TAP_OFFSET = 2;
	localparam int MAX_TAP = 5;
	localparam int MAX_WINDOW_SEL = 6;
	localparam int MAX_DELAY_SEL = 10;

	localparam int WINDOW_MIN_PPM = 500;
	localparam int DELAY_MIN_CYCLES = 32;
	localparam int PLL_MAX_KHZ = 333000;
	localparam int CORE_FAST_MAX_KHZ = 166000;
	localparam int CORE_STD_MAX_KHZ = 142000;
	localparam int USB_MIN_KHZ = 30000;
	localparam int CAN_STEP_KHZ = 8000;
	localparam int REF_KHZ_DEFAULT = 25000;

endpackage : aligned_clock_pkg

/* File: lock_delay_filter.sv */
// Lock qualification: phase-error window compare and lock-delay counter.
// Assumes synchronised inputs and a one-cycle reference tick on hclk.
`timescale 1ns/1ps
module lock_delay_filter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ref_tick,
	input wire logic pll_running,
	input wire logic [15:0] phase_error_ppm,
	input wire logic [2:0] window_sel,
	input wire logic [3:0] delay_sel,
	output logic raw_lock,
	output logic lock
);
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic lock_reg;
	logic lock_next;
	wire [15:0] window_ppm = 16'(aligned_clock_pkg::WINDOW_MIN_PPM) << window_sel;
	wire [15:0] delay_target = 16'(aligned_clock_pkg::DELAY_MIN_CYCLES) << delay_sel;

	// Lock is judged inside the programmed phase-error window
	assign raw_lock = pll_running && (phase_error_ppm <= window_ppm);
	// Count reference cycles while raw lock holds, until lock sets; any loss restarts
	assign count_next = !raw_lock ? 16'h0000 :
		(ref_tick && !lock_reg) ? count_reg + 16'h0001 : count_reg;
	// Loss drops lock at once; only the rise is delayed
	assign lock_next = raw_lock && (lock_reg || (count_next >= delay_target));
	assign lock = lock_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 16'h0000;
			lock_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			lock_reg <= lock_next;
		end
	end
endmodule : lock_delay_filter

/* File: aligned_clock_pll_divider.sv */
// Aligned clock generator: AHB-Lite registers, lock logic, divider chain.
// Assumes hclk stands for the PLL output; derived clocks leave as enables.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module aligned_clock_pll_divider #(
	parameter int REF_KHZ = aligned_clock_pkg::REF_KHZ_DEFAULT,
	parameter bit FAST_GRADE = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic base_reference_clock,
	input wire logic standby_clock,
	input wire logic pll_running,
	input wire logic [15:0] phase_error_ppm,
	output logic pll_lock_out,
	output logic fabric_pll_lock,
	output logic lock_gained_irq,
	output logic lock_lost_irq,
	output logic memory_fast_clock_en,
	output logic core_clock_en,
	output logic core_clock_gated_en,
	output logic config_interface_clock_en,
	output logic apb0_clock_en,
	output logic apb1_clock_en,
	output logic fabric_interface_clock_a_en,
	output logic fabric_interface_clock_b_en,
	output logic memory_fabric_interface_clock_en,
	output logic soft_controller_interface_clock_en
);
	// Synchronisers for pins from other clock domains
	logic [2:0] ref_sync_reg;
	logic [2:0] stby_sync_reg;
	logic [15:0] perr_meta_reg;
	logic [15:0] perr_sync_reg;
	logic [1:0] run_sync_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_sync_reg <= 3'h0;
			stby_sync_reg <= 3'h0;
			perr_meta_reg <= 16'hFFFF;
			perr_sync_reg <= 16'hFFFF;
			run_sync_reg <= 2'h0;
		end else begin
			ref_sync_reg <= {ref_sync_reg[1:0], base_reference_clock};
			stby_sync_reg <= {stby_sync_reg[1:0], standby_clock};
			perr_meta_reg <= phase_error_ppm;
			perr_sync_reg <= perr_meta_reg;
			run_sync_reg <= {run_sync_reg[0], pll_running};
		end
	end

	// Edge detects look only at the second and third stages
	wire ref_tick = ref_sync_reg[1] & ~ref_sync_reg[2];
	wire stby_tick = stby_sync_reg[1] & ~stby_sync_reg[2];

	// Register file
	logic [24:0] cfg_reg;
	logic [24:0] cfg_next;
	logic [12:0] lock_cfg_reg;
	logic [12:0] lock_cfg_next;
	logic cfg_err_reg;
	logic cfg_err_next;
	logic load_reg;
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	logic [31:0] hrdata_reg;

	// Legality of a full divider and PLL setting
	function automatic logic config_ok(input logic [24:0] c, input logic [12:0] l);
		logic [31:0] a_div;
		logic [31:0] core_div;
		logic [31:0] ratio;
		logic [31:0] pll_khz;
		logic [31:0] core_max;
		logic [31:0] n_mf;
		logic [2:0] bc;
		logic [2:0] b0;
		logic [2:0] b1;
		logic [2:0] bmf;
		logic ok;
		bc = c[aligned_clock_pkg::CORE_TAP_POS +: 3];
		b0 = c[aligned_clock_pkg::APB0_TAP_POS +: 3];
		b1 = c[aligned_clock_pkg::APB1_TAP_POS +: 3];
		bmf = c[aligned_clock_pkg::MEM_FIC_TAP_POS +: 3];
		a_div = 32'(c[aligned_clock_pkg::STAGE_A_POS +: 2]) + 32'd1;
		core_div = a_div << bc;
		ratio = core_div;
		n_mf = a_div << bmf;
		pll_khz = 32'(REF_KHZ) * 32'(l[aligned_clock_pkg::MULT_POS +: 5]);
		core_max = FAST_GRADE ? 32'(aligned_clock_pkg::CORE_FAST_MAX_KHZ) :
			32'(aligned_clock_pkg::CORE_STD_MAX_KHZ);
		ok = 1'b1;
		if (a_div > 32'd3) ok = 1'b0;
		if ((bc > 3'(aligned_clock_pkg::MAX_TAP)) || (b0 > 3'(aligned_clock_pkg::MAX_TAP)) ||
			(b1 > 3'(aligned_clock_pkg::MAX_TAP)) || (bmf > 3'(aligned_clock_pkg::MAX_TAP)) ||
			(c[aligned_clock_pkg::FIC_A_TAP_POS +: 3] > 3'(aligned_clock_pkg::MAX_TAP)) ||
			(c[aligned_clock_pkg::FIC_B_TAP_POS +: 3] > 3'(aligned_clock_pkg::MAX_TAP)))
			ok = 1'b0;
		if (!(ratio == 32'd1 || ratio == 32'd2 || ratio == 32'd3 || ratio == 32'd4 ||
			ratio == 32'd6 || ratio == 32'd8)) ok = 1'b0;
		if ((b0 < bc) || (b0 > bc + 3'd3) || (b1 < bc) || (b1 > bc + 3'd3))
			ok = 1'b0;
		if (c[aligned_clock_pkg::SMC_MODE_POS] && (ratio != 32'd1)) ok = 1'b0;
		if (a_div == 32'd3) begin
			if (bmf > 3'd2) ok = 1'b0;
		end else if (n_mf > 32'd16) begin
			ok = 1'b0;
		end
		if ((l[aligned_clock_pkg::MULT_POS +: 5] == 5'h00) ||
			(pll_khz > 32'(aligned_clock_pkg::PLL_MAX_KHZ))) ok = 1'b0;
		if (pll_khz > core_max * core_div) ok = 1'b0;
		if (c[aligned_clock_pkg::USB_EN_POS] &&
			(pll_khz <= 32'(aligned_clock_pkg::USB_MIN_KHZ) * core_div)) ok = 1'b0;
		if (c[aligned_clock_pkg::CAN_EN_POS] &&
			((pll_khz % (32'(aligned_clock_pkg::CAN_STEP_KHZ) * (a_div << b1))) != 32'd0))
			ok = 1'b0;
		if (l[aligned_clock_pkg::WINDOW_POS +: 3] > 3'(aligned_clock_pkg::MAX_WINDOW_SEL))
			ok = 1'b0;
		if (l[aligned_clock_pkg::DELAY_POS +: 4] > 4'(aligned_clock_pkg::MAX_DELAY_SEL))
			ok = 1'b0;
		return ok;
	endfunction : config_ok

	// Bus decode
	wire addr_phase = hsel && hready && htrans[1];
	wire wr_cfg = wr_pend_reg && (addr_reg == aligned_clock_pkg::CFG_OFFSET);
	wire wr_lock = wr_pend_reg && (addr_reg == aligned_clock_pkg::LOCK_CFG_OFFSET);
	wire [24:0] cand_cfg = wr_cfg ? hwdata[24:0] : cfg_reg;
	wire [12:0] cand_lock = wr_lock ? hwdata[12:0] : lock_cfg_reg;
	wire cand_ok = config_ok(cand_cfg, cand_lock);
	wire any_cfg_wr = wr_cfg || wr_lock;

	// An illegal setting is refused whole and the old one kept
	assign cfg_next = (any_cfg_wr && cand_ok) ? cand_cfg : cfg_reg;
	assign lock_cfg_next = (any_cfg_wr && cand_ok) ? cand_lock : lock_cfg_reg;
	assign cfg_err_next = any_cfg_wr ? !cand_ok : cfg_err_reg;

	logic raw_lock;
	logic lock;
	logic standby_active_reg;
	wire [31:0] status_word = {28'h0000000, standby_active_reg, cfg_err_reg, raw_lock, lock};
	wire sel_cfg = (haddr[7:0] == aligned_clock_pkg::CFG_OFFSET) && (haddr[31:8] == 24'h000000);
	wire sel_lock = (haddr[7:0] == aligned_clock_pkg::LOCK_CFG_OFFSET) &&
		(haddr[31:8] == 24'h000000);
	wire sel_stat = (haddr[7:0] == aligned_clock_pkg::STATUS_OFFSET) &&
		(haddr[31:8] == 24'h000000);
	wire [31:0] read_mux = sel_cfg ? {7'h00, cfg_next} :
		sel_lock ? {19'h00000, lock_cfg_next} :
		sel_stat ? status_word : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
			cfg_reg <= aligned_clock_pkg::CFG_RESET;
			lock_cfg_reg <= aligned_clock_pkg::LOCK_CFG_RESET;
			cfg_err_reg <= 1'b0;
			load_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
			addr_reg <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				hrdata_reg <= read_mux;
			end
			cfg_reg <= cfg_next;
			lock_cfg_reg <= lock_cfg_next;
			cfg_err_reg <= cfg_err_next;
			load_reg <= any_cfg_wr && cand_ok;
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Lock qualification
	lock_delay_filter u_lock (
		.hclk(hclk),
		.hresetn(hresetn),
		.ref_tick(ref_tick),
		.pll_running(run_sync_reg[1]),
		.phase_error_ppm(perr_sync_reg),
		.window_sel(lock_cfg_reg[aligned_clock_pkg::WINDOW_POS +: 3]),
		.delay_sel(lock_cfg_reg[aligned_clock_pkg::DELAY_POS +: 4]),
		.raw_lock(raw_lock),
		.lock(lock)
	);

	logic lock_d_reg;
	logic gained_reg;
	logic lost_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_d_reg <= 1'b0;
			gained_reg <= 1'b0;
			lost_reg <= 1'b0;
		end else begin
			lock_d_reg <= lock;
			gained_reg <= lock && !lock_d_reg;
			lost_reg <= !lock && lock_d_reg;
		end
	end
	assign pll_lock_out = lock_d_reg;
	assign fabric_pll_lock = lock_d_reg;
	assign lock_gained_irq = gained_reg;
	assign lock_lost_irq = lost_reg;

	// Common counter chain: stage A then a binary stage B counter
	logic [1:0] a_cnt_reg;
	logic [6:0] b_cnt_reg;
	wire [1:0] a_last = cfg_reg[aligned_clock_pkg::STAGE_A_POS +: 2];
	wire a_wrap = (a_cnt_reg == a_last);
	localparam int TAP_LAST = aligned_clock_pkg::TAP_COUNT - 1;
	wire [TAP_LAST:0] tap_en;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_cnt_reg <= 2'h0;
			b_cnt_reg <= 7'h00;
		end else if (load_reg) begin
			// Restart from zero so every tap leaves aligned
			a_cnt_reg <= 2'h0;
			b_cnt_reg <= 7'h00;
		end else if (a_wrap) begin
			a_cnt_reg <= 2'h0;
			b_cnt_reg <= b_cnt_reg + 7'h01;
		end else begin
			a_cnt_reg <= a_cnt_reg + 2'h1;
		end
	end

	// Tap k fires when the low k bits are all ones, so slower taps land on faster ones
	genvar k;
	generate
		for (k = 0; k < aligned_clock_pkg::TAP_COUNT; k = k + 1) begin : g_tap
			wire [6:0] mask = 7'((8'h01 << k) - 8'h01);
			assign tap_en[k] = a_wrap && ((b_cnt_reg & mask) == mask);
		end
	endgenerate

	// Output switching between standby and divided clocks happens at a chain wrap or a configuration load,
	// so all three multiplexers move on the same edge.
	wire chain_wrap = a_wrap && (b_cnt_reg == 7'h7F);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			standby_active_reg <= 1'b1;
		end else if (chain_wrap || load_reg) begin
			standby_active_reg <= cfg_reg[aligned_clock_pkg::STANDBY_POS];
		end
	end

	wire core_tap = tap_en[cfg_reg[aligned_clock_pkg::CORE_TAP_POS +: 3]];
	wire cfg_if_tap = tap_en[cfg_reg[aligned_clock_pkg::CORE_TAP_POS +: 3] +
		3'(aligned_clock_pkg::CFG_IF_TAP_OFFSET)];
	wire core_src = standby_active_reg ? stby_tick : core_tap;
	wire apb0_src = standby_active_reg ? stby_tick :
		tap_en[cfg_reg[aligned_clock_pkg::APB0_TAP_POS +: 3]];
	wire apb1_src = standby_active_reg ? stby_tick :
		tap_en[cfg_reg[aligned_clock_pkg::APB1_TAP_POS +: 3]];
	wire smc_mode = cfg_reg[aligned_clock_pkg::SMC_MODE_POS];

	// Enables are registered, one cycle behind the chain, all with the same lag
	logic [9:0] en_reg;
	wire [9:0] en_next = {
		smc_mode && !standby_active_reg && core_tap,
		!smc_mode && !standby_active_reg &&
			tap_en[cfg_reg[aligned_clock_pkg::MEM_FIC_TAP_POS +: 3]],
		!standby_active_reg && tap_en[cfg_reg[aligned_clock_pkg::FIC_B_TAP_POS +: 3]],
		!standby_active_reg && tap_en[cfg_reg[aligned_clock_pkg::FIC_A_TAP_POS +: 3]],
		apb1_src,
		apb0_src,
		!standby_active_reg && cfg_if_tap,
		core_src && !cfg_reg[aligned_clock_pkg::CORE_GATE_POS],
		core_src,
		!standby_active_reg // Memory clock is stopped on standby
	};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_reg <= 10'h000;
		end else begin
			en_reg <= en_next;
		end
	end

	assign memory_fast_clock_en = en_reg[0];
	assign core_clock_en = en_reg[1];
	assign core_clock_gated_en = en_reg[2];
	assign config_interface_clock_en = en_reg[3];
	assign apb0_clock_en = en_reg[4];
	assign apb1_clock_en = en_reg[5];
	assign fabric_interface_clock_a_en = en_reg[6];
	assign fabric_interface_clock_b_en = en_reg[7];
	assign memory_fabric_interface_clock_en = en_reg[8];
	assign soft_controller_interface_clock_en = en_reg[9];
endmodule : aligned_clock_pll_divider

/* File: aligned_clock_sva.sv */
// Port checker for the aligned clock PLL divider.
// Assumes it is bound onto the design top; reset is async, active low.
`timescale 1ns/1ps
module aligned_clock_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pll_running,
	input wire logic pll_lock_out,
	input wire logic fabric_pll_lock,
	input wire logic lock_gained_irq,
	input wire logic lock_lost_irq,
	input wire logic memory_fast_clock_en,
	input wire logic core_clock_en,
	input wire logic core_clock_gated_en,
	input wire logic config_interface_clock_en,
	input wire logic apb0_clock_en,
	input wire logic apb1_clock_en,
	input wire logic memory_fabric_interface_clock_en,
	input wire logic soft_controller_interface_clock_en
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Saturates so a long wait cannot wrap back under the bound
	logic [7:0] run_cnt_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) run_cnt_reg <= 8'h00;
		else if (!pll_running) run_cnt_reg <= 8'h00;
		else if (run_cnt_reg != 8'hFF) run_cnt_reg <= run_cnt_reg + 8'h01;
	end
	a_gain_pulse: assert property (
		$rose(pll_lock_out) |-> lock_gained_irq ##1 !lock_gained_irq) else $error("gain irq");
	a_lost_pulse: assert property (
		$fell(pll_lock_out) |-> lock_lost_irq ##1 !lock_lost_irq) else $error("lost irq");
	a_fabric_copy: assert property (
		fabric_pll_lock == pll_lock_out) else $error("fabric lock differs");
	a_lock_delay: assert property (
		$rose(pll_lock_out) |-> run_cnt_reg >= 8'h40) else $error("lock too early");
	a_lock_drop: assert property (
		!pll_running [*8] |-> !pll_lock_out) else $error("lock without pll");
	a_gate_core: assert property (
		core_clock_gated_en |-> core_clock_en) else $error("gated core off grid");
	a_cfgif_core: assert property (
		memory_fast_clock_en && config_interface_clock_en |-> core_clock_en)
		else $error("cfg clock off core grid");
	a_apb0_core: assert property (
		memory_fast_clock_en && apb0_clock_en |-> core_clock_en) else $error("apb0 off grid");
	a_apb1_core: assert property (
		memory_fast_clock_en && apb1_clock_en |-> core_clock_en) else $error("apb1 off grid");
	a_soft_excl: assert property (
		!(memory_fabric_interface_clock_en && soft_controller_interface_clock_en))
		else $error("both memory fabric clocks");
endmodule : aligned_clock_chk
bind aligned_clock_pll_divider aligned_clock_chk aligned_clock_chk_i (.hclk(hclk),
	.hresetn(hresetn), .pll_running(pll_running), .pll_lock_out(pll_lock_out),
	.fabric_pll_lock(fabric_pll_lock), .lock_gained_irq(lock_gained_irq),
	.lock_lost_irq(lock_lost_irq), .memory_fast_clock_en(memory_fast_clock_en),
	.core_clock_en(core_clock_en), .core_clock_gated_en(core_clock_gated_en),
	.config_interface_clock_en(config_interface_clock_en), .apb0_clock_en(apb0_clock_en),
	.apb1_clock_en(apb1_clock_en),
	.memory_fabric_interface_clock_en(memory_fabric_interface_clock_en),
	.soft_controller_interface_clock_en(soft_controller_interface_clock_en));

/* File: fabric_clock_model.sv */
// Fabric side: base clock, standby oscillator, PLL status, lock consumer.
// Assumes the bench sets run and err between scenarios.
`timescale 1ns/1ps
module fabric_clock_model (
	input wire logic run,
	input wire logic [15:0] err,
	input wire logic fabric_pll_lock,
	output logic base_reference_clock,
	output logic standby_clock,
	output logic pll_running,
	output logic [15:0] phase_error_ppm,
	output logic lock_seen
);
	// Base clock is the slowest clock handed over, eight bus cycles a period
	initial base_reference_clock = 1'b0;
	always #80 base_reference_clock = ~base_reference_clock;
	// Standby oscillator runs free, unrelated in phase
	initial standby_clock = 1'b0;
	always #47 standby_clock = ~standby_clock;
	assign pll_running = run;
	assign phase_error_ppm = err;
	// Fabric logic watches lock directly, no register path
	assign lock_seen = fabric_pll_lock;
endmodule : fabric_clock_model

/* File: tb_top.sv */
// Self-checking bench for the aligned clock PLL divider.
// Assumes a 50 MHz hclk and the fabric model on the far side.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready, hreadyout, hresp, pll_lock_out, fabric_pll_lock, lock_gained_irq;
	logic lock_lost_irq, base_reference_clock, standby_clock, pll_running, lock_seen;
	logic [31:0] hrdata, rd, good;
	logic [15:0] phase_error_ppm;
	logic [15:0] err = 16'h0;
	logic run = 1'b0;
	logic gained = 1'b0;
	logic lost = 1'b0;
	logic [9:0] en;
	int miscompares = 0;
	int comparisons = 0;
	int cnt [10];
	int t;
	always #10 hclk = ~hclk;
	assign hready = hreadyout;
	always @(posedge hclk) begin
		if (lock_gained_irq === 1'b1) gained <= 1'b1;
		if (lock_lost_irq === 1'b1) lost <= 1'b1;
	end
	aligned_clock_pll_divider aligned_clock_pll_divider_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .base_reference_clock(base_reference_clock),
		.standby_clock(standby_clock), .pll_running(pll_running),
		.phase_error_ppm(phase_error_ppm), .pll_lock_out(pll_lock_out),
		.fabric_pll_lock(fabric_pll_lock), .lock_gained_irq(lock_gained_irq),
		.lock_lost_irq(lock_lost_irq), .memory_fast_clock_en(en[0]), .core_clock_en(en[1]),
		.core_clock_gated_en(en[2]), .config_interface_clock_en(en[3]),
		.apb0_clock_en(en[4]), .apb1_clock_en(en[5]), .fabric_interface_clock_a_en(en[6]),
		.fabric_interface_clock_b_en(en[7]), .memory_fabric_interface_clock_en(en[8]),
		.soft_controller_interface_clock_en(en[9]));
	fabric_clock_model fabric_clock_model_i (.run(run), .err(err),
		.fabric_pll_lock(fabric_pll_lock), .base_reference_clock(base_reference_clock),
		.standby_clock(standby_clock), .pll_running(pll_running),
		.phase_error_ppm(phase_error_ppm), .lock_seen(lock_seen));
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask : bus
	function automatic logic [31:0] cfg(input int a, c, p0, p1, fa, fb, mf, hi);
		return 32'((hi << 20) | (mf << 17) | (fb << 14) | (fa << 11) | (p1 << 8) | (p0 << 5)
			| (c << 2) | a);
	endfunction : cfg
	task automatic wait_lock(input logic v);
		t = 0;
		while (lock_seen !== v && t < 5000) begin
			@(posedge hclk);
			t++;
		end
		// Irq pulse rises on the same edge as the lock output
		repeat (3) @(posedge hclk);
		`CHK(lock_seen, v)
	endtask : wait_lock
	task automatic div_check(input int a, c, p0, p1, fa, fb, mf, hi);
		int q, e [10];
		q = a + 1;
		good = cfg(a, c, p0, p1, fa, fb, mf, hi);
		bus(1'b1, 32'h0, good);
		bus(1'b0, 32'h0, 32'h0);
		`CHK(rd, good)
		// Standby hand-over happens on the configuration load, not at a chain wrap
		repeat (400) @(posedge hclk);
		cnt = '{default: 0};
		repeat (768) begin
			@(negedge hclk);
			for (int i = 0; i < 10; i++) cnt[i] += en[i];
		end
		e = '{768, 768 / (q << c), 768 / (q << c), 768 / (q << (c + 2)), 768 / (q << p0),
			768 / (q << p1), 768 / (q << fa), 768 / (q << fb), hi[0] ? 0 : 768 / (q << mf),
			hi[0] ? 768 / (q << c) : 0};
		for (int i = 0; i < 10; i++) `CHK(cnt[i], e[i])
	endtask : div_check
	task automatic refuse(input logic [31:0] v);
		bus(1'b1, 32'h0, v);
		bus(1'b0, 32'h0, 32'h0);
		`CHK(rd, good)
		bus(1'b0, 32'h8, 32'h0);
		`CHK(rd[2], 1'b1)
	endtask : refuse
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0, 32'h0);
		`CHK(rd, 32'h00400000)
		bus(1'b0, 32'h4, 32'h0);
		`CHK(rd, 32'h00000100)
		bus(1'b0, 32'hC, 32'h0);
		`CHK(rd, 32'h0)
		$display("register test done");
		for (int s = 0; s <= 6; s++) begin
			bus(1'b1, 32'h4, 32'h100 | 32'(s));
			gained <= 1'b0;
			lost <= 1'b0;
			err <= 16'(500 << s) + 16'h1;
			run <= 1'b1;
			repeat (400) @(posedge hclk);
			`CHK(pll_lock_out, 1'b0)
			err <= 16'(500 << s);
			wait_lock(1'b1);
			`CHK(pll_lock_out, 1'b1)
			`CHK(gained, 1'b1)
			run <= 1'b0;
			wait_lock(1'b0);
			`CHK(lost, 1'b1)
		end
		$display("lock window test done");
		err <= 16'h0;
		for (int d = 0; d <= 2; d++) begin
			bus(1'b1, 32'h4, 32'h100 | 32'(d << 4));
			run <= 1'b1;
			wait_lock(1'b1);
			`CHK(t >= (256 << d) - 8 && t <= (256 << d) + 24, 1'b1)
			run <= 1'b0;
			wait_lock(1'b0);
		end
		$display("lock delay test done");
		div_check(0, 1, 2, 4, 5, 0, 4, 0);
		div_check(2, 0, 0, 3, 1, 5, 1, 0);
		div_check(0, 0, 1, 0, 2, 3, 0, 1);
		$display("divider test done");
		refuse(cfg(3, 0, 0, 0, 0, 0, 0, 0));
		refuse(cfg(2, 2, 2, 2, 2, 2, 0, 0));
		refuse(cfg(0, 1, 0, 1, 0, 0, 0, 0));
		refuse(cfg(0, 0, 0, 4, 0, 0, 0, 0));
		refuse(cfg(1, 0, 0, 0, 0, 0, 0, 1));
		refuse(cfg(2, 0, 0, 0, 0, 0, 3, 0));
		refuse(cfg(0, 0, 0, 0, 0, 0, 5, 0));
		refuse(cfg(0, 0, 0, 0, 0, 0, 0, 8));
		refuse(cfg(0, 0, 0, 0, 0, 0, 0, 16));
		// A core ratio of 2 lets the faster PLL setting in before the 1:1 refusal
		good = cfg(0, 1, 1, 1, 0, 0, 0, 0);
		bus(1'b1, 32'h0, good);
		bus(1'b1, 32'h4, 32'h700);
		bus(1'b1, 32'h4, 32'hE00);
		bus(1'b0, 32'h4, 32'h0);
		`CHK(rd, 32'h00000700)
		refuse(cfg(0, 0, 0, 0, 0, 0, 0, 0));
		$display("refusal test done");
		print_verdict();
	end
	initial begin
		#600000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : tb_top
